//--- psf_pkg.sv
// Package for the status flag bank: register codes, page values, bit places.
// Assumes both ends share one clock and one synchronous active-low reset.
// How it works
// [R01] Temperature bit 7 latches over-temperature fault.
// [R02] Temperature bit 6 latches over-temperature warning.
// [R03] Unsupported and reserved bits read zero always.
// [R04] Writing one clears temperature or vendor flag.
// [R05] Only single-byte reads and writes reach registers.
// [R06] Vendor byte paged; page FFh reads channel A.
// [R07] Communication byte shared, page ignored.
// [R08] Communication bit 7 latches bad command.
// [R09] Communication bit 6 latches bad payload.
// [R10] Communication bit 5 latches checksum failure.
// [R11] Communication bit 3 latches memory error.
// [R12] Communication bit 1 latches other communication faults.
// [R13] Writing one clears communication flag bits.
// [R14] Vendor bit 7 latches power stage fault.
// [R15] Vendor bit 6 latches open sense pin.
// [R16] Too many phases sets bit 5, clamps count.
// [R17] Vendor bit 4 records temp sense level.
// [R18] Vendor bit 3, channel A only, voltage-id reset.
// [R19] Vendor bit 0 after seven imbalance cycles.
// [R20] Temperature byte paged like vendor byte.
// [R21] Set wins over a simultaneous clear.
package psf_pkg;
   localparam logic [7:0] CMD_TEMP   = 8'h7D;
   localparam logic [7:0] CMD_COMM   = 8'h7E;
   localparam logic [7:0] CMD_VENDOR = 8'h80;
   localparam logic [7:0] CMD_PAGE   = 8'h00;
   localparam logic [7:0] PAGE_A     = 8'h00;
   localparam logic [7:0] PAGE_B     = 8'h01;
   localparam logic [7:0] PAGE_ALL   = 8'hFF;
   localparam logic [7:0] TEMP_MASK   = 8'hC0;
   localparam logic [7:0] COMM_MASK   = 8'hEA;
   localparam logic [7:0] VEND_MASK_A = 8'hF9;
   localparam logic [7:0] VEND_MASK_B = 8'hF1;
   localparam int BIT_OTF   = 7;
   localparam int BIT_OTW   = 6;
   localparam int BIT_BCMD  = 7;
   localparam int BIT_BPAY  = 6;
   localparam int BIT_CSUM  = 5;
   localparam int BIT_MEM   = 3;
   localparam int BIT_MISC  = 1;
   localparam int BIT_PS    = 7;
   localparam int BIT_SENSE = 6;
   localparam int BIT_CLAMP = 5;
   localparam int BIT_TSNS  = 4;
   localparam int BIT_VID   = 3;
   localparam int BIT_PHF   = 0;
   localparam logic [2:0] IMBAL_CYCLES = 3'h7;
   localparam logic [7:0] RESET_FLAGS  = 8'h00;
   localparam logic [7:0] RESET_PAGE   = 8'h00;
   localparam logic [2:0] MAX_PHASES_A = 3'h3;
   localparam logic [2:0] MAX_PHASES_B = 3'h1;

   typedef enum logic [1:0] {
      PSF_OP_IDLE  = 2'b00,
      PSF_OP_READ  = 2'b01,
      PSF_OP_WRITE = 2'b11
   } psf_op_t;

   function automatic logic [7:0] psf_latch(input logic [7:0] cur,
                                            input logic [7:0] set,
                                            input logic [7:0] clr,
                                            input logic [7:0] mask);
      psf_latch = (set | (cur & ~clr)) & mask;
   endfunction
endpackage

//--- psf_if.sv
// Byte transaction link between host end and flag bank.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface psf_if (
   input wire logic clk
);
   logic       rd;
   logic       wr;
   logic [7:0] cmd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rvalid;

   modport dev (
      input  rd,
      input  wr,
      input  cmd,
      input  wdata,
      output rdata,
      output rvalid
   );
   modport host (
      output rd,
      output wr,
      output cmd,
      output wdata,
      input  rdata,
      input  rvalid
   );
endinterface
`default_nettype wire

//--- psf_device.sv
// Device end: paged temperature and vendor bytes, shared communication byte.
// Assumes event inputs are one-cycle pulses from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module psf_device (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   psf_if.dev              bus,
   input  wire logic [1:0] overtemp_fault,
   input  wire logic [1:0] overtemp_warn,
   input  wire logic       bad_command,
   input  wire logic       bad_payload,
   input  wire logic       checksum_error,
   input  wire logic       memory_error,
   input  wire logic       misc_comm_fault,
   input  wire logic [1:0] power_stage_fault,
   input  wire logic [1:0] sense_pin_open,
   input  wire logic [1:0] temp_sense_high,
   input  wire logic [1:0] temp_sense_sample,
   input  wire logic       voltage_id_reset,
   input  wire logic [1:0] imbalance_tick,
   input  wire logic [1:0] imbalance_warn,
   input  wire logic [2:0] phases_req_a,
   input  wire logic [2:0] phases_req_b,
   output logic      [2:0] phases_act_a,
   output logic      [2:0] phases_act_b,
   output logic      [7:0] page
);
   logic [7:0] temp_r [2];
   logic [7:0] vend_r [2];
   logic [7:0] comm_r;
   logic [2:0] imb_cnt_r [2];
   logic [7:0] page_r;
   logic [7:0] rdata_r;
   logic       rvalid_r;
   logic       ch_b;
   logic       clr_temp;
   logic       clr_comm;
   logic       clr_vend;
   logic [1:0] clamp_a;
   logic [1:0] phf_set;

   // One decode serves the page register and all three clear strobes.
   function automatic logic code_hit(input logic       strobe,
                                     input logic [7:0] code,
                                     input logic [7:0] want);
      code_hit = strobe && code == want;
   endfunction

   // Channel A answers every page but 01h, page FFh included.
   function automatic logic ch_sel(input int   c,
                                   input logic sel_b);
      ch_sel = (c == 1) ? sel_b : !sel_b;
   endfunction

   assign page = page_r;
   assign ch_b = (page_r == psf_pkg::PAGE_B); // [R06] [R20]
   assign clr_temp = code_hit(bus.wr, bus.cmd, psf_pkg::CMD_TEMP); // [R05]
   assign clr_comm = code_hit(bus.wr, bus.cmd, psf_pkg::CMD_COMM);
   assign clr_vend = code_hit(bus.wr, bus.cmd, psf_pkg::CMD_VENDOR);
   assign clamp_a = {phases_req_b > psf_pkg::MAX_PHASES_B,
                     phases_req_a > psf_pkg::MAX_PHASES_A};

   // Clamped phase count; the request itself is never altered.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         phases_act_a <= 3'h0;
         phases_act_b <= 3'h0;
      end else if (ce) begin
         phases_act_a <= clamp_a[0] ? psf_pkg::MAX_PHASES_A
                                    : phases_req_a; // [R16]
         phases_act_b <= clamp_a[1] ? psf_pkg::MAX_PHASES_B
                                    : phases_req_b; // [R16]
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         page_r <= psf_pkg::RESET_PAGE;
      end else if (ce && code_hit(bus.wr, bus.cmd, psf_pkg::CMD_PAGE)) begin
         page_r <= bus.wdata;
      end
   end

   // The imbalance counter restarts whenever a detection cycle is clean.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         imb_cnt_r[0] <= 3'h0;
         imb_cnt_r[1] <= 3'h0;
      end else if (ce) begin
         for (int c = 0; c < 2; c++) begin
            if (imbalance_tick[c]) begin
               if (!imbalance_warn[c])
                  imb_cnt_r[c] <= 3'h0;
               else if (imb_cnt_r[c] != psf_pkg::IMBAL_CYCLES)
                  imb_cnt_r[c] <= imb_cnt_r[c] + 3'h1; // [R19]
            end
         end
      end
   end

   // The counter saturates, so every further warned tick sets the flag
   // again: a clear during a lasting imbalance does not hide it.
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         phf_set[c] = imbalance_tick[c] && imbalance_warn[c] &&
                      imb_cnt_r[c] >= psf_pkg::IMBAL_CYCLES - 3'h1; // [R19]
      end
   end

   // Temperature flags, one byte per channel.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         temp_r[0] <= psf_pkg::RESET_FLAGS;
         temp_r[1] <= psf_pkg::RESET_FLAGS;
      end else if (ce) begin
         for (int c = 0; c < 2; c++) begin
            logic [7:0] tset;
            logic [7:0] tclr;
            tset = 8'h00;
            tset[psf_pkg::BIT_OTF] = overtemp_fault[c]; // [R01]
            tset[psf_pkg::BIT_OTW] = overtemp_warn[c]; // [R02]
            tclr = (clr_temp && ch_sel(c, ch_b)) ? bus.wdata : 8'h00; // [R04]
            // A set in the same cycle as its clear survives.
            temp_r[c] <= psf_pkg::psf_latch(temp_r[c], tset, tclr,
                                            psf_pkg::TEMP_MASK); // [R21] [R03]
         end
      end
   end

   // Vendor flags; the voltage-id bit exists on channel A only.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         vend_r[0] <= psf_pkg::RESET_FLAGS;
         vend_r[1] <= psf_pkg::RESET_FLAGS;
      end else if (ce) begin
         for (int c = 0; c < 2; c++) begin
            logic [7:0] vset;
            logic [7:0] vclr;
            logic [7:0] vmask;
            vset = 8'h00;
            vset[psf_pkg::BIT_PS]    = power_stage_fault[c]; // [R14]
            vset[psf_pkg::BIT_SENSE] = sense_pin_open[c]; // [R15]
            vset[psf_pkg::BIT_CLAMP] = clamp_a[c]; // [R16]
            vset[psf_pkg::BIT_VID]   = (c == 0) && voltage_id_reset; // [R18]
            vset[psf_pkg::BIT_PHF]   = phf_set[c]; // [R19]
            vclr = (clr_vend && ch_sel(c, ch_b)) ? bus.wdata : 8'h00; // [R04]
            vmask = (c == 0) ? psf_pkg::VEND_MASK_A : psf_pkg::VEND_MASK_B;
            vend_r[c] <= psf_pkg::psf_latch(vend_r[c], vset, vclr,
                                            vmask); // [R21] [R03]
            // The level bit is a record, not a latch: it follows each
            // sample, so a clear write only hides it until the next one.
            if (temp_sense_sample[c]) begin
               vend_r[c][psf_pkg::BIT_TSNS] <= temp_sense_high[c]; // [R17]
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         comm_r <= psf_pkg::RESET_FLAGS;
      end else if (ce) begin
         logic [7:0] cset;
         cset = 8'h00;
         cset[psf_pkg::BIT_BCMD] = bad_command; // [R08]
         cset[psf_pkg::BIT_BPAY] = bad_payload; // [R09]
         cset[psf_pkg::BIT_CSUM] = checksum_error; // [R10]
         cset[psf_pkg::BIT_MEM]  = memory_error; // [R11]
         cset[psf_pkg::BIT_MISC] = misc_comm_fault; // [R12]
         // One copy for both channels; the page plays no part.
         comm_r <= psf_pkg::psf_latch(comm_r, cset,
                      clr_comm ? bus.wdata : 8'h00,
                      psf_pkg::COMM_MASK); // [R07] [R13] [R21]
      end
   end

   // Exactly one byte comes back, one cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else if (ce) begin
         rvalid_r <= bus.rd; // [R05]
         if (bus.rd) begin
            case (bus.cmd)
               psf_pkg::CMD_TEMP:   rdata_r <= temp_r[ch_b]; // [R20]
               psf_pkg::CMD_COMM:   rdata_r <= comm_r; // [R07]
               psf_pkg::CMD_VENDOR: rdata_r <= vend_r[ch_b]; // [R06]
               psf_pkg::CMD_PAGE:   rdata_r <= page_r;
               default:             rdata_r <= 8'h00;
            endcase
         end
      end
   end

   assign bus.rdata  = rdata_r;
   assign bus.rvalid = rvalid_r;
endmodule
`default_nettype wire

//--- psf_host.sv
// Host end: turns software port strobes into single-byte transactions.
// Assumes software strobes are one cycle and never both at once.
`timescale 1ns/1ps
`default_nettype none
module psf_host (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   psf_if.host             bus,
   input  wire logic [7:0] sw_addr,
   input  wire logic [7:0] sw_wdata,
   input  wire logic       sw_wr,
   input  wire logic       sw_rd,
   output logic      [7:0] sw_rdata,
   output logic            sw_busy
);
   psf_pkg::psf_op_t op_r;
   logic [7:0]       cmd_r;
   logic [7:0]       wdata_r;
   logic [7:0]       rdata_r;

   // Each strobe becomes one single-byte transaction on the link.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         op_r    <= psf_pkg::PSF_OP_IDLE;
         cmd_r   <= 8'h00;
         wdata_r <= 8'h00;
      end else if (ce) begin
         if (sw_wr) begin
            op_r    <= psf_pkg::PSF_OP_WRITE; // [R05]
            cmd_r   <= sw_addr;
            wdata_r <= sw_wdata; // [R04] [R13]
         end else if (sw_rd) begin
            op_r  <= psf_pkg::PSF_OP_READ; // [R05]
            cmd_r <= sw_addr;
         end else begin
            op_r <= psf_pkg::PSF_OP_IDLE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn)
         rdata_r <= 8'h00;
      else if (ce && bus.rvalid)
         rdata_r <= bus.rdata; // [R06] [R20]
   end

   assign bus.rd    = (op_r == psf_pkg::PSF_OP_READ);
   assign bus.wr    = (op_r == psf_pkg::PSF_OP_WRITE);
   assign bus.cmd   = cmd_r;
   assign bus.wdata = wdata_r;
   assign sw_rdata  = rdata_r;
   assign sw_busy   = (op_r != psf_pkg::PSF_OP_IDLE) || bus.rvalid;
endmodule
`default_nettype wire

//--- psf_link_sva.sv
// Checker for the byte link between the host end and the flag bank.
// Assumes it sits beside the link interface, on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
module psf_link_sva (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       rd,
   input wire logic       wr,
   input wire logic [7:0] cmd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       rvalid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence rd_of(c);
      rd && cmd == c;
   endsequence
   read_answer_a: assert property (rd |=> rvalid)
      else $error("read strobe without answer");
   answer_cause_a: assert property (rvalid |-> $past(rd))
      else $error("answer without read strobe");
   strobe_excl_a: assert property (!(rd && wr))
      else $error("read and write strobes together");
   write_silent_a: assert property (wr |=> !rvalid)
      else $error("write produced an answer");
   temp_zero_a: assert property (rd_of(psf_pkg::CMD_TEMP) |=>
      rdata[5:0] == 6'h00) else $error("temperature reserved bits set");
   comm_zero_a: assert property (rd_of(psf_pkg::CMD_COMM) |=>
      (rdata & ~psf_pkg::COMM_MASK) == 8'h00)
      else $error("communication reserved bits set");
   vend_zero_a: assert property (rd_of(psf_pkg::CMD_VENDOR) |=>
      rdata[2:1] == 2'h0) else $error("vendor reserved bits set");
   unknown_zero_a: assert property (rd && !(cmd inside {8'h00, 8'h7D,
      8'h7E, 8'h80}) |=> rdata == 8'h00) else $error("unknown code not zero");
   rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
      else $error("read data moved without a read");
endmodule
`default_nettype wire

//--- pmbus_status_flag_bank_tb.sv
// Self-checking bench: host end and flag bank joined by the byte link.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pmbus_status_flag_bank_tb;
   logic        clk = 1'b0, resetn = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
   logic [7:0]  sw_addr = 8'h00, sw_wdata = 8'h00, sw_rdata, page, rv, pg;
   logic [1:0]  ot_f = 2'h0, ot_w = 2'h0, ps_f = 2'h0, sn_o = 2'h0;
   logic [1:0]  ts_h = 2'h0, ts_s = 2'h0, im_t = 2'h0, im_w = 2'h0;
   logic        bcmd = 1'b0, bpay = 1'b0, csum = 1'b0, mem = 1'b0;
   logic        misc = 1'b0, vid = 1'b0, sw_busy;
   logic [2:0]  req_a = 3'h0, req_b = 3'h0, act_a, act_b;
   logic [7:0]  tx [2] = '{8'h00, 8'h00};
   logic [7:0]  vx [2] = '{8'h00, 8'h00};
   logic [7:0]  cx = 8'h00;
   logic [31:0] r = 32'h63A6;
   int          n_mismatch = 0, samples_checked = 0, cycles = 0;
   always #20 clk = ~clk;
   psf_if u_psf_if (.clk(clk));
   psf_host u_psf_host (.clk(clk), .resetn(resetn), .ce(1'b1),
      .bus(u_psf_if.host), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sw_busy(sw_busy));
   psf_device u_psf_device (.clk(clk), .resetn(resetn), .ce(1'b1),
      .bus(u_psf_if.dev), .overtemp_fault(ot_f), .overtemp_warn(ot_w),
      .bad_command(bcmd), .bad_payload(bpay), .checksum_error(csum),
      .memory_error(mem), .misc_comm_fault(misc), .power_stage_fault(ps_f),
      .sense_pin_open(sn_o), .temp_sense_high(ts_h),
      .temp_sense_sample(ts_s), .voltage_id_reset(vid),
      .imbalance_tick(im_t), .imbalance_warn(im_w), .phases_req_a(req_a),
      .phases_req_b(req_b), .phases_act_a(act_a), .phases_act_b(act_b),
      .page(page));
   psf_link_sva u_psf_link_sva (.clk(clk), .resetn(resetn),
      .rd(u_psf_if.rd), .wr(u_psf_if.wr), .cmd(u_psf_if.cmd),
      .wdata(u_psf_if.wdata), .rdata(u_psf_if.rdata),
      .rvalid(u_psf_if.rvalid));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction
   task automatic check(input string what, input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      repeat (3) @(posedge clk);
      #1 d = sw_rdata;
   endtask
   task automatic check_all(input logic [7:0] p);
      int c;
      c = (p == psf_pkg::PAGE_B) ? 1 : 0;
      bus_wr(psf_pkg::CMD_PAGE, p);
      bus_rd(psf_pkg::CMD_TEMP, rv);
      check("page", page, p);
      check("temp", rv, tx[c]);
      bus_rd(psf_pkg::CMD_COMM, rv);
      check("comm", rv, cx);
      bus_rd(psf_pkg::CMD_VENDOR, rv);
      check("vendor", rv, vx[c]);
      check("busy", {7'h00, sw_busy}, 8'h00);
   endtask
   task automatic clear_all(input logic [7:0] p, w);
      int c;
      c = (p == psf_pkg::PAGE_B) ? 1 : 0;
      bus_wr(psf_pkg::CMD_PAGE, p);
      bus_wr(psf_pkg::CMD_TEMP, w);
      tx[c] &= ~w;
      bus_wr(psf_pkg::CMD_COMM, w);
      cx &= ~w;
      bus_wr(psf_pkg::CMD_VENDOR, w);
      vx[c] &= ~w;
   endtask
   // Events last one cycle and never meet a clear, except where meant to.
   task automatic fire(input logic [31:0] e);
      @(posedge clk);
      {ts_s, ts_h, sn_o, ps_f, ot_w, ot_f} <= e[11:0];
      {vid, misc, mem, csum, bpay, bcmd} <= e[17:12];
      req_a <= e[20:18];
      req_b <= e[23:21];
      @(posedge clk);
      {ts_s, sn_o, ps_f, ot_w, ot_f} <= 10'h000;
      {vid, misc, mem, csum, bpay, bcmd} <= 6'h00;
      req_a <= 3'h0;
      req_b <= 3'h0;
      for (int c = 0; c < 2; c++) begin
         tx[c] |= {e[c], e[2+c], 6'h00};
         vx[c] |= {e[4+c], e[6+c], 6'h00};
         if (e[10+c])
            vx[c][4] = e[8+c];
      end
      vx[0][5] |= e[20:18] > psf_pkg::MAX_PHASES_A;
      vx[1][5] |= e[23:21] > psf_pkg::MAX_PHASES_B;
      vx[0][3] |= e[17];
      cx |= {e[12], e[13], e[14], 1'b0, e[15], 1'b0, e[16], 1'b0};
      #1 check("act_a", 8'(act_a), 8'(e[20:18] > psf_pkg::MAX_PHASES_A ?
         psf_pkg::MAX_PHASES_A : e[20:18]));
      check("act_b", 8'(act_b), 8'(e[23:21] > psf_pkg::MAX_PHASES_B ?
         psf_pkg::MAX_PHASES_B : e[23:21]));
   endtask
   task automatic ticks(input int n, input logic [1:0] w);
      repeat (n) begin
         @(posedge clk);
         im_t <= 2'h3;
         im_w <= w;
         @(posedge clk);
         im_t <= 2'h0;
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      check_all(psf_pkg::PAGE_A);
      for (int i = 0; i < 40; i++) begin
         r = xs(r);
         fire(r);
         pg = r[25:24] == 2'h0 ? psf_pkg::PAGE_A :
              r[25:24] == 2'h1 ? psf_pkg::PAGE_B : psf_pkg::PAGE_ALL;
         check_all(pg);
         clear_all(pg, r[31:24]);
      end
      bus_wr(8'h55, 8'hFF);
      bus_rd(8'h55, rv);
      check("unmapped", rv, 8'h00);
      // The clear lands on the same edge as a new bad-command pulse.
      bus_wr(psf_pkg::CMD_COMM, 8'hFF);
      bcmd <= 1'b1;
      @(posedge clk);
      bcmd <= 1'b0;
      cx = 8'h80;
      ticks(6, 2'h3);
      ticks(1, 2'h0);
      check_all(psf_pkg::PAGE_B);
      ticks(7, 2'h3);
      vx[0][0] = 1'b1;
      vx[1][0] = 1'b1;
      check_all(psf_pkg::PAGE_ALL);
      check_all(psf_pkg::PAGE_B);
      // A clear during a lasting imbalance is undone by the next tick.
      clear_all(psf_pkg::PAGE_B, 8'h01);
      ticks(1, 2'h3);
      vx[1][0] = 1'b1;
      check_all(psf_pkg::PAGE_B);
      final_report();
   end
endmodule
`default_nettype wire
